//--- src/rtca_top.v
// Clock/alarm value registers, calibration, alarm and power window timer
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "rtca_regs.vh"
// Function
// - Minute tens bits 14-12, ones 11-8, BCD
// - Second tens bits 6-4, ones 3-0, BCD
// - Unused value bits read zero, ignore writes
// - Month tens bit 12, ones 11-8; day 5-0
// - Weekday 10-8, hour tens 5-4, ones 3-0
// - Alarm weekday/hour, month/day and window writes need write enable; alarm minutes/seconds do not
// - Stability length bits 15-8, 0 to 255
// - Stability timer starts each alarm when enabled
// - Sample length bits 7-0; all-ones always open
// - Sample follows stability; zero stability starts directly
// - Signed calibration times four applied each minute
// - Negative calibration removes pulses each minute
// - Alarm enable bit 15 of alarm config
// - Single-shot and repeating alarm, half-second to year
// - Four-bit mask selects interval, upper codes reserved
// - Repeat counter decrements; chime rolls; else disables
// - Window pointer selects value, decrements on high
// - Power control enable and output polarity bits
module rtca_top #(
   parameter HALF_SEC_CLKS = `RTCA_HALF_SEC_CLKS
) (
   input  wire        sys_clk,
   input  wire        rstn,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [4:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        timebase_pin_i,
   input  wire [15:0] time_month_day_i,
   input  wire [15:0] time_weekday_hours_i,
   output reg         alarm_event_o,
   output reg         pwc_out_o,
   output reg         sample_window_o
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_STAB = 2'h1;
   localparam ST_SAMP = 2'h2;

   reg  [15:0]        cfg_q;
   reg  [15:0]        pwr_q;
   reg  [15:0]        alm_cfg_q;
   reg  [15:0]        alm_time_minutes_seconds_q;
   reg  [15:0]        alm_wdhr_q;
   reg  [15:0]        alm_mthdy_q;
   reg  [15:0]        time_minutes_seconds_q;
   reg  [15:0]        win_q;
   reg  signed [17:0] presc_q;
   reg                half_q;
   reg                tick_q;
   reg  [1:0]         pst_q;
   reg  [7:0]         pcnt_q;
   reg  [15:0]        rd_d;
   reg  [15:0]        win_val;
   reg  [15:0]        time_minutes_seconds_d;
   wire               tb_rise;
   wire               acc;
   wire               wr;
   wire               rd;
   wire [2:0]         idx;
   wire               wren;
   wire [1:0]         ptr;
   wire               alm_hit;
   wire [15:0]        wmask;
   wire [15:0]        wdat;
   wire signed [17:0] cal_adj;
   wire               minute_edge;

   rtca_pin_sync u_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin_i   (timebase_pin_i),
      .rise_o  (tb_rise)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Byte-lane merge restricted to implemented bits
   function [15:0] merge;
      input [15:0] old;
      input [15:0] nw;
      input [15:0] bmask;
      input [15:0] impl;
      reg   [15:0] m;
      begin
         m     = bmask & impl;
         merge = (old & ~m) | (nw & m);
      end
   endfunction

   // Interval match for a given mask code
   function alarm_match;
      input [3:0]  code;
      input        full_sec;
      input [15:0] ms;
      input [15:0] ams;
      input [15:0] wd;
      input [15:0] awd;
      input [15:0] md;
      input [15:0] amd;
      reg          s1;
      reg          s2;
      reg          m1;
      reg          m2;
      reg          h;
      begin
         s1 = ms[3:0] == ams[3:0];
         s2 = ms[6:0] == ams[6:0];
         m1 = s2 && ms[11:8] == ams[11:8];
         m2 = s2 && ms[14:8] == ams[14:8];
         h  = m2 && wd[5:0] == awd[5:0];
         case (code)
            4'h0: alarm_match = 1'b1;
            4'h1: alarm_match = full_sec;
            4'h2: alarm_match = full_sec & s1;
            4'h3: alarm_match = full_sec & s2;
            4'h4: alarm_match = full_sec & m1;
            4'h5: alarm_match = full_sec & m2;
            4'h6: alarm_match = full_sec & h;
            4'h7: alarm_match = full_sec & h & (wd[10:8] == awd[10:8]);
            4'h8: alarm_match = full_sec & h & (md[5:0] == amd[5:0]);
            4'h9: alarm_match = full_sec & h & (md[12:0] == amd[12:0]);
            default: alarm_match = 1'b0;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr    = acc & wb_we_i;
   assign rd    = acc & ~wb_we_i;
   assign idx   = wb_adr_i[4:2];
   assign wren  = cfg_q[`RTCA_CFG_WREN];
   assign ptr   = alm_cfg_q[9:8];
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdat  = wb_dat_i[15:0];

   // Alarm value seen through the window
   always @* begin
      case (ptr)
         2'h0:    win_val = alm_time_minutes_seconds_q;
         2'h1:    win_val = alm_wdhr_q;
         2'h2:    win_val = alm_mthdy_q;
         default: win_val = `RTCA_RST_ZERO16;
      endcase
   end

   always @* begin
      case (idx)
         `RTCA_IDX_CFG_CAL:      rd_d = cfg_q;
         `RTCA_IDX_PWR_CTRL:     rd_d = pwr_q;
         `RTCA_IDX_ALARM_CFG:    rd_d = alm_cfg_q;
         `RTCA_IDX_ALARM_WINDOW: rd_d = win_val;
         `RTCA_IDX_TIME_TIME_MINUTES_SECONDS:  rd_d = time_minutes_seconds_q;
         `RTCA_IDX_WIN_TIMERS:   rd_d = win_q;
         default:                rd_d = `RTCA_RST_ZERO16;
      endcase
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= acc;
         wb_dat_o <= rd ? {16'h0000, rd_d} : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Timebase prescaler and calibration
   // ------------------------------------------------------------
   // Adjust once a minute, at the full-second tick while seconds read 00
   assign minute_edge = tick_q & half_q & (time_minutes_seconds_q[6:0] == 7'h00);
   assign cal_adj = {{8{cfg_q[7]}}, cfg_q[7:0], 2'b00};

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         presc_q <= 18'sd0;
         half_q  <= 1'b0;
         tick_q  <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (!cfg_q[`RTCA_CFG_TIMER_ON]) begin
            presc_q <= 18'sd0;
         end else if (minute_edge) begin
            // Positive adds pulses, negative removes them
            presc_q <= presc_q + cal_adj;
         end else if (tb_rise) begin
            if (presc_q >= $signed(HALF_SEC_CLKS - 1)) begin
               presc_q <= 18'sd0;
               half_q  <= ~half_q;
               tick_q  <= 1'b1;
            end else begin
               presc_q <= presc_q + 18'sd1;
            end
         end
      end
   end

   // BCD seconds and minutes advance on each full second
   always @* begin
      time_minutes_seconds_d = time_minutes_seconds_q;
      if (time_minutes_seconds_q[3:0] != 4'h9) begin
         time_minutes_seconds_d[3:0] = time_minutes_seconds_q[3:0] + 4'h1;
      end else begin
         time_minutes_seconds_d[3:0] = 4'h0;
         if (time_minutes_seconds_q[6:4] != 3'h5) begin
            time_minutes_seconds_d[6:4] = time_minutes_seconds_q[6:4] + 3'h1;
         end else begin
            time_minutes_seconds_d[6:4] = 3'h0;
            if (time_minutes_seconds_q[11:8] != 4'h9) begin
               time_minutes_seconds_d[11:8] = time_minutes_seconds_q[11:8] + 4'h1;
            end else begin
               time_minutes_seconds_d[11:8] = 4'h0;
               if (time_minutes_seconds_q[14:12] != 3'h5) begin
                  time_minutes_seconds_d[14:12] = time_minutes_seconds_q[14:12] + 3'h1;
               end else begin
                  time_minutes_seconds_d[14:12] = 3'h0;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Registers, alarm sequencing
   // ------------------------------------------------------------
   assign alm_hit = tick_q & alm_cfg_q[`RTCA_ALM_EN] &
                    alarm_match(alm_cfg_q[13:10], ~half_q, time_minutes_seconds_q,
                                alm_time_minutes_seconds_q, time_weekday_hours_i,
                                alm_wdhr_q, time_month_day_i,
                                alm_mthdy_q);

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_q        <= `RTCA_RST_ZERO16;
         pwr_q        <= `RTCA_RST_ZERO16;
         alm_cfg_q    <= `RTCA_RST_ZERO16;
         alm_time_minutes_seconds_q <= `RTCA_RST_ZERO16;
         alm_wdhr_q   <= `RTCA_RST_ZERO16;
         alm_mthdy_q  <= `RTCA_RST_ZERO16;
         time_minutes_seconds_q     <= `RTCA_RST_ZERO16;
         win_q        <= `RTCA_RST_ZERO16;
      end else begin
         if (wr && idx == `RTCA_IDX_CFG_CAL) begin
            cfg_q <= merge(cfg_q, wdat, wmask, `RTCA_CFG_MASK);
         end
         if (wr && idx == `RTCA_IDX_PWR_CTRL) begin
            pwr_q <= merge(pwr_q, wdat, wmask, `RTCA_PWR_MASK);
         end
         if (wr && idx == `RTCA_IDX_WIN_TIMERS && wren) begin
            win_q <= merge(win_q, wdat, wmask, 16'hffff);
         end
         // Software write to the time value wins over the tick
         if (wr && idx == `RTCA_IDX_TIME_TIME_MINUTES_SECONDS) begin
            time_minutes_seconds_q <= merge(time_minutes_seconds_q, wdat, wmask,
                              `RTCA_TIME_MINUTES_SECONDS_MASK);
         end else if (tick_q && half_q) begin
            time_minutes_seconds_q <= time_minutes_seconds_d;
         end
         if (wr && idx == `RTCA_IDX_ALARM_WINDOW) begin
            case (ptr)
               2'h0: alm_time_minutes_seconds_q <= merge(alm_time_minutes_seconds_q, wdat, wmask,
                                        `RTCA_TIME_MINUTES_SECONDS_MASK);
               `RTCA_PTR_WD: if (wren) begin
                  alm_wdhr_q <= merge(alm_wdhr_q, wdat, wmask,
                                      `RTCA_WDHR_MASK);
               end
               `RTCA_PTR_MD: if (wren) begin
                  alm_mthdy_q <= merge(alm_mthdy_q, wdat, wmask,
                                       `RTCA_MTHDY_MASK);
               end
               default: ;
            endcase
         end
         // Alarm event beats a same-cycle software config write
         if (alm_hit) begin
            if (alm_cfg_q[7:0] != 8'h00) begin
               alm_cfg_q[7:0] <= alm_cfg_q[7:0] - 8'h01;
            end else if (alm_cfg_q[`RTCA_ALM_CHIME]) begin
               alm_cfg_q[7:0] <= `RTCA_RPT_ROLL;
            end else begin
               alm_cfg_q[`RTCA_ALM_EN] <= 1'b0;
            end
         end else if (wr && idx == `RTCA_IDX_ALARM_CFG) begin
            alm_cfg_q <= merge(alm_cfg_q, wdat, wmask, 16'hffff);
         end else if (acc && idx == `RTCA_IDX_ALARM_WINDOW &&
                      wb_sel_i[1] && ptr != 2'h0) begin
            alm_cfg_q[9:8] <= ptr - 2'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Power control stability and sample windows
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pst_q           <= ST_IDLE;
         pcnt_q          <= 8'h00;
         alarm_event_o   <= 1'b0;
         pwc_out_o       <= 1'b0;
         sample_window_o <= 1'b0;
      end else begin
         alarm_event_o <= alm_hit;
         if (alm_hit && pwr_q[`RTCA_PWR_EN]) begin
            if (win_q[15:8] == 8'h00) begin
               pst_q  <= ST_SAMP;
               pcnt_q <= win_q[7:0];
            end else begin
               pst_q  <= ST_STAB;
               pcnt_q <= win_q[15:8];
            end
         end else begin
            case (pst_q)
               ST_STAB: begin
                  if (pcnt_q == 8'h00) begin
                     pst_q  <= ST_SAMP;
                     pcnt_q <= win_q[7:0];
                  end else if (tb_rise) begin
                     pcnt_q <= pcnt_q - 8'h01;
                  end
               end
               ST_SAMP: begin
                  if (pcnt_q == 8'h00 || !pwr_q[`RTCA_PWR_EN]) begin
                     pst_q <= ST_IDLE;
                  end else if (tb_rise) begin
                     pcnt_q <= pcnt_q - 8'h01;
                  end
               end
               default: pst_q <= ST_IDLE;
            endcase
         end
         // Output is active through both windows
         pwc_out_o <= ~(pwr_q[`RTCA_PWR_POL] ^
                        (pwr_q[`RTCA_PWR_EN] && pst_q != ST_IDLE));
         sample_window_o <= (win_q[7:0] == `RTCA_SAMP_OPEN) ||
                            (pst_q == ST_SAMP && pcnt_q != 8'h00);
      end
   end
endmodule // rtca_top

//--- src/rtca_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef RTCA_REGS_VH
`define RTCA_REGS_VH

// ---------------------------------------------------------------
// Register word indices (index in adr[4:2])
// ---------------------------------------------------------------
`define RTCA_IDX_CFG_CAL        3'h0
`define RTCA_IDX_PWR_CTRL       3'h1
`define RTCA_IDX_ALARM_CFG      3'h2
`define RTCA_IDX_ALARM_WINDOW   3'h3
`define RTCA_IDX_TIME_TIME_MINUTES_SECONDS    3'h4
`define RTCA_IDX_WIN_TIMERS     3'h5

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RTCA_CFG_TIMER_ON       15
`define RTCA_CFG_WREN           13
`define RTCA_PWR_EN             15
`define RTCA_PWR_POL            14
`define RTCA_ALM_EN             15
`define RTCA_ALM_CHIME          14

// Implemented bits of each value layout; all others read zero
`define RTCA_TIME_MINUTES_SECONDS_MASK        16'h7f7f
`define RTCA_MTHDY_MASK         16'h1f3f
`define RTCA_WDHR_MASK          16'h073f
`define RTCA_PWR_MASK           16'hc000
`define RTCA_CFG_MASK           16'ha0ff

// ---------------------------------------------------------------
// Reset value, window pointer codes, repeat roll and sample-open codes
// ---------------------------------------------------------------
`define RTCA_RST_ZERO16         16'h0000
`define RTCA_PTR_WD             2'h1
`define RTCA_PTR_MD             2'h2
`define RTCA_RPT_ROLL           8'hff
`define RTCA_SAMP_OPEN          8'hff

// ---------------------------------------------------------------
// Timing: timebase edges per half second, calibration scale
// ---------------------------------------------------------------
`define RTCA_HALF_SEC_CLKS      16384
`define RTCA_CAL_SHIFT          2

`endif

//--- src/rtca_pin_sync.v
// Three-flop pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module rtca_pin_sync (
   input  wire sys_clk,
   input  wire rstn,
   input  wire pin_i,
   output reg  rise_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg lvl_q;

   // First flop feeds only the second
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1_q   <= 1'b0;
         s2_q   <= 1'b0;
         s3_q   <= 1'b0;
         lvl_q  <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         s1_q   <= pin_i;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
         rise_o <= (s2_q == s3_q) & s3_q & ~lvl_q;
      end
   end
endmodule // rtca_pin_sync

//--- tb/rtca_top_asserts.sv
// Bus handshake and alarm output assertions for the alarm block
`timescale 1ns/1ps
module rtca_asserts (
   input wire        sys_clk,
   input wire        rstn,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [4:0]  wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        alarm_event_o
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ------------------------------------------------------------
   // Request and read cycle shapes
   // ------------------------------------------------------------
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd(idx);
      s_req ##0 (!wb_we_i && wb_adr_i[4:2] == idx) ##1 wb_ack_o;
   endsequence
   bus_ack_a: assert property (s_req |=> wb_ack_o)
      else $error("request not acked");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   dat_upper_a: assert property (wb_dat_o[31:16] == 16'h0)
      else $error("upper read data not zero");
   time_minutes_seconds_gap_a: assert property (s_rd(3'h4) |-> !wb_dat_o[15] && !wb_dat_o[7])
      else $error("unused time bit set");
   unmapped_read_a: assert property (s_rd(3'h6) or s_rd(3'h7) |-> wb_dat_o == 0)
      else $error("unmapped read not zero");
   alarm_pulse_a: assert property (alarm_event_o |=> !alarm_event_o)
      else $error("alarm event longer than one cycle");
endmodule // rtca_asserts

bind rtca_top rtca_asserts u_chk (
   .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarm_event_o(alarm_event_o));

//--- tb/tb_rtca_top.sv
// Self-checking bench for the clock alarm and power window block
`timescale 1ns/1ps
module tb_rtca_top;
   localparam HALF = 8;
   reg         sys_clk, rstn, cyc, stb, we, pin;
   reg  [4:0]  adr;
   reg  [31:0] dat;
   reg  [15:0] rd;
   wire [31:0] rdat;
   wire        ack, evt, pwc, samp;
   reg         p;
   reg  [3:0]  sel;
   integer     num_errors, checks, cyc_cnt, n, d, w, i;
   rtca_top #(.HALF_SEC_CLKS(HALF)) DUT (
      .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .timebase_pin_i(pin),
      .time_month_day_i(16'h0101), .time_weekday_hours_i(16'h0000),
      .alarm_event_o(evt), .pwc_out_o(pwc), .sample_window_o(samp));
   initial begin
      sys_clk = 0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Timebase pin: one rise every 8 clocks; hang guard
   always @(posedge sys_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      pin     <= cyc_cnt[2];
      if (cyc_cnt == 90000) begin
         num_errors = num_errors + 1;
         report_and_stop;
      end
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task report_and_stop;
      begin
         if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task step;
      @(posedge sys_clk);
   endtask
   task bus(input wr, input [2:0] idx, input [15:0] wd);
      integer t;
      begin
         cyc <= 1;
         stb <= 1;
         we  <= wr;
         adr <= {idx, 2'b00};
         dat <= {16'h0, wd};
         t = 0;
         step;
         while (ack !== 1'b1 && t < 20) begin
            step;
            t = t + 1;
         end
         rd = rdat[15:0];
         cyc <= 0;
         stb <= 0;
         if (t == 20) chk(32'h1, 32'h0);
         step;
      end
   endtask
   task rd_chk(input [2:0] idx, input [15:0] exp);
      begin
         bus(0, idx, 16'h0);
         chk({16'h0, rd}, {16'h0, exp});
      end
   endtask
   task wait_evt;
      begin
         d = 0;
         while (evt !== 1'b1 && d < 9000) begin
            step;
            d = d + 1;
         end
         if (d == 9000) chk(32'h1, 32'h0);
      end
   endtask
   task pwc_meas;
      begin
         wait_evt;
         d = 0;
         while (samp !== 1'b1 && d < 40) begin
            step;
            d = d + 1;
         end
         p = pwc;
         w = 0;
         while (samp === 1'b1 && w < 300) begin
            step;
            w = w + 1;
         end
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_layout;
      begin
         for (i = 0; i < 8; i = i + 1) rd_chk(i, 16'h0000);
         bus(1, 4, 16'hffff); rd_chk(4, 16'h7f7f);
         bus(1, 3, 16'hffff); rd_chk(3, 16'h7f7f);
         bus(1, 5, 16'h1234); rd_chk(5, 16'h0000);
         bus(1, 2, 16'h0200); bus(1, 3, 16'hffff); rd_chk(2, 16'h0100);
         bus(1, 0, 16'h2000);
         bus(1, 5, 16'h1234); rd_chk(5, 16'h1234);
         bus(1, 2, 16'h0200); bus(1, 3, 16'hffff); bus(1, 3, 16'hffff);
         bus(1, 2, 16'h0200); rd_chk(3, 16'h1f3f);
         rd_chk(3, 16'h073f);
         rd_chk(3, 16'h7f7f); rd_chk(3, 16'h7f7f);
         // Low byte lane only: the minute digits must survive
         sel <= 4'h1;
         bus(1, 4, 16'h0000);
         rd_chk(4, 16'h7f00);
         sel <= 4'h3;
         bus(1, 3, 16'h0000); bus(1, 4, 16'h0000); bus(1, 5, 16'h0000);
      end
   endtask
   // A config write in an event cycle is lost, so sync to an event first
   task t_masks;
      begin
         bus(1, 0, 16'ha000);
         for (i = 0; i < 16; i = i + 1) if (i < 3 || i > 9) begin
            if (i > 0 && i < 11) wait_evt;
            bus(1, 2, {2'b11, i[3:0], 10'h0});
            n = 0;
            repeat (i == 1 ? 256 : i == 2 ? 2560 : 128) begin
               step;
               if (evt === 1'b1) n = n + 1;
            end
            chk(n, i < 3 ? 2 : 0);
         end
         bus(1, 2, 16'h8002);
         n = 0;
         repeat (400) begin
            step;
            if (evt === 1'b1) n = n + 1;
         end
         chk(n, 3);
         rd_chk(2, 16'h0000);
         bus(1, 2, 16'hc000);
         wait_evt;
         rd_chk(2, 16'hc0ff);
         // Ten-minute and hour masks, time preset just short of a match
         wait_evt;
         for (i = 4; i < 6; i = i + 1) begin
            bus(1, 2, {2'b11, i[3:0], 10'h0});
            bus(1, 4, i == 4 ? 16'h0958 : 16'h5958);
            n = 0;
            repeat (384) begin
               step;
               if (evt === 1'b1) n = n + 1;
            end
            chk(n, 1);
         end
         bus(1, 2, 16'hc000);
      end
   endtask
   task t_power;
      begin
         bus(1, 5, 16'h00ff);
         repeat (3) step;
         chk(samp, 1);
         // Window first, so no event opens a long sample window early
         bus(1, 5, 16'h0203);
         bus(1, 1, 16'hc000);
         pwc_meas;
         chk(d >= 9 && d <= 18, 1);
         chk(w >= 23 && w <= 25, 1);
         chk(p, 1);
         bus(1, 1, 16'h8000);
         bus(1, 5, 16'h0003);
         pwc_meas;
         chk(d <= 3, 1);
         chk(p, 0);
      end
   endtask
   task t_cal(input [7:0] cal, input integer gap);
      begin
         bus(1, 0, {8'h20, cal});
         bus(1, 0, {8'ha0, cal});
         wait_evt;
         step;
         wait_evt;
         chk(d + 1, gap);
      end
   endtask
   initial begin
      num_errors = 0;
      checks = 0;
      cyc_cnt = 0;
      rstn = 0;
      cyc = 0;
      stb = 0;
      we = 0;
      adr = 0;
      dat = 0;
      pin = 0;
      sel = 4'h3;
      repeat (10) step;
      rstn <= 1;
      step;
      t_layout;
      t_masks;
      t_power;
      wait_evt;
      bus(1, 2, 16'hcc00);
      t_cal(8'hff, 7712);
      t_cal(8'h01, 7648);
      report_and_stop;
   end
endmodule // tb_rtca_top
